// >>> fck_params.svh
// constants for the frame classification key builder: offsets, field
// positions, reset values and the frame type codes it compares against
`ifndef FCK_PARAMS_SVH
`define FCK_PARAMS_SVH

// frame type, header field and protocol codes
`define FCK_TYPE_OVERLOAD_FIELD_MIN      16'h0600
`define FCK_TYPE_OVERLOAD_FIELD_IPV4     16'h0800
`define FCK_TYPE_OVERLOAD_FIELD_IPV6     16'h86DD
`define FCK_IP_VER4        4'h4
`define FCK_IP_VER6        4'h6
`define FCK_LLC_SNAP_HDR   24'hAAAA03
`define FCK_PROTO_TCP      8'h06
`define FCK_PROTO_UDP      8'h11
`define FCK_IHL_PLAIN      4'h5
`define FCK_V4_MC_NIBBLE   4'hE
`define FCK_V6_MC_BYTE     8'hFF

// register offsets (byte addresses)
`define FCK_ADDR_W         8
`define FCK_OFS_ADV_CFG    8'h00
`define FCK_OFS_FRAME_CNT  8'h04
`define FCK_OFS_LAST_FLAGS 8'h08

// advanced_class_config layout
`define FCK_CFG_DST_LSB    0
`define FCK_CFG_DST_W      4
`define FCK_CFG_DSCP_LSB   4
`define FCK_CFG_DSCP_W     2
`define FCK_CFG_RESET      6'h00
`define FCK_CNT_RESET      16'h0000

`endif

// >>> fck_pkg.sv
// types for the frame classification key builder
// assumes fck_params.svh is compiled alongside
`default_nettype none

package fck_pkg;

    // fields handed over by the ingress frame parser, one frame per valid
    typedef struct packed {
        logic [47:0]      dest_mac_field;
        logic [47:0]      src_mac;
        logic [15:0]      type_len;
        logic [3:0]       ip_version;
        logic [7:0]       dsap;
        logic [7:0]       ssap;
        logic [7:0]       llc_ctrl;
        logic [4:0][7:0]  snap_pid;
        logic [0:3][7:0]  payload;
        logic             more_frags;
        logic [12:0]      frag_offset;
        logic [3:0]       ihl;
        logic [5:0]       dscp;
        logic [7:0]       protocol;
        logic [31:0]      src_ip;
        logic [31:0]      dst_ip;
        logic [7:0]       dst_ip6_top;
        logic [15:0]      l4_dport;
        logic             oam_y1731;
    } fck_parse_t;

    // per-lookup context from the lookup engine
    typedef struct packed {
        logic             first_lookup;
        logic [1:0]       next_key_type;
        logic [5:0]       classified_dscp;
    } fck_lookup_t;

    typedef struct packed {
        logic [47:0]      mac_key_field;
        logic             ip_multicast_flag;
        logic             ethertype_encoded_flag;
        logic [15:0]      type_overload_field;
        logic             ip_or_llc_subnet_flag;
        logic             ipv4_flag;
        logic             fragmented_flag;
        logic             nonfirst_fragment_flag;
        logic             header_options_flag;
        logic [5:0]       dscp_key_field;
        logic [31:0]      dest_ip_field;
        logic [31:0]      src_ip_overload_field;
        logic [7:0]       protocol_key_field;
        logic             transport_flag;
        logic             stream_protocol_flag;
        logic             dst_entry;
    } fck_key_t;

endpackage

`default_nettype wire

// >>> fck_key_builder.sv
// frame classification key builder: turns parsed frame fields into key
// flags and overloaded key fields, one registered cycle after the parser
// assumes parser and lookup engine share sys_clk_in; no back-pressure
//
// Notes on behaviour
// - destination select puts destination MAC, and for IP frames destination IP, into source key fields.
// - destination select comes from config indexed by the current lookup's next_key_type.
// - ip multicast flag on IPv4 top nibble 0xE or IPv6 top byte 0xFF.
// - ethertype encoded flag only when type/length is at least 0x600.
// - length frames: type field is DSAP,SSAP for LLC or PID bytes 4,3 for SNAP.
// - IP frames with transport flag: type field is the TRANSPORT_FLAG destination port.
// - IP frames without TRANSPORT_FLAG: type field is the IP protocol number.
// - other ethertype frames: type field is the EtherType itself.
// - IP-or-SNAP flag on 0x0800 with version 4 or 0x86DD with version 6.
// - length frames: IP-or-SNAP flag when LLC header bytes are AA-AA-03.
// - IPv4 flag only for EtherType 0x800 with version 4.
// - fragmented flag for IPv4 with more-fragments set or nonzero offset.
// - non-first fragment flag only for IPv4 with nonzero offset.
// - options flag when IPv4 header length exceeds 5; options never parsed.
// - DSCP field from IP frames (zero otherwise), or classified DSCP when per-lookup enable set.
// - destination IP field is IPv4 address or low 32 bits of IPv6.
// - source IP field carries LLC, SNAP or payload bytes for non-IP frames.
// - IP frames: source IP field is IPv4 source or low 32 bits of IPv6.
// - protocol field is IPv4 protocol or IPv6 next header.
// - transport flag for protocol 6 or 17, forced on for OAM Y.1731.
// - stream protocol flag for IPv4 or IPv6 protocol 6.
`timescale 1ns/1ps
`default_nettype none
`include "fck_params.svh"

module fck_key_builder
    import fck_pkg::*;
(
    // clock and reset
    input  wire logic                    sys_clk_in,
    input  wire logic                    resetn_in,
    // parser side and per-lookup context from the lookup engine
    input  wire logic                    parse_valid_in,
    input  wire fck_parse_t              parse_in,
    input  wire fck_lookup_t             lookup_in,
    // lookup engine side
    output logic                         key_valid_out,
    output fck_key_t                     key_out,
    // register port
    input  wire logic [`FCK_ADDR_W-1:0]  reg_addr_in,
    input  wire logic [31:0]             reg_wdata_in,
    input  wire logic                    reg_wr_in,
    input  wire logic                    reg_rd_in,
    output logic [31:0]                  reg_rdata_out
);

    function automatic logic is_transport(input logic [7:0] proto);
        is_transport = (proto == `FCK_PROTO_TCP) || (proto == `FCK_PROTO_UDP);
    endfunction

    function automatic logic is_ipv4(input fck_parse_t p);
        is_ipv4 = (p.type_len == `FCK_TYPE_OVERLOAD_FIELD_IPV4) && (p.ip_version == `FCK_IP_VER4);
    endfunction

    function automatic logic is_ipv6(input fck_parse_t p);
        is_ipv6 = (p.type_len == `FCK_TYPE_OVERLOAD_FIELD_IPV6) && (p.ip_version == `FCK_IP_VER6);
    endfunction

    // advanced_class_config: one destination-select bit per next_key_type,
    // one use_classified_dscp_enable bit per lookup (first, second)
    logic [`FCK_CFG_DST_W-1:0]   dst_sel_cfg_q;
    logic [`FCK_CFG_DSCP_W-1:0]  use_cl_dscp_cfg_q;
    logic [15:0]                 frame_cnt_q;
    logic [31:0]                 rdata_q;
    logic                        key_valid_q;
    fck_key_t                    key_q;
    fck_key_t                    key_d;

    // decoded frame class
    logic                        type_overload_field_enc;
    logic                        ip4;
    logic                        ip6;
    logic                        ip_any;
    logic                        snap;
    logic                        dst_sel;
    logic                        use_cl_dscp;

    always_comb begin
        type_overload_field_enc   = parse_in.type_len >= `FCK_TYPE_OVERLOAD_FIELD_MIN;
        ip4         = type_overload_field_enc && is_ipv4(parse_in);
        ip6         = type_overload_field_enc && is_ipv6(parse_in);
        ip_any      = ip4 || ip6;
        snap        = !type_overload_field_enc &&
                      ({parse_in.dsap, parse_in.ssap, parse_in.llc_ctrl} ==
                       `FCK_LLC_SNAP_HDR);
        dst_sel     = dst_sel_cfg_q[lookup_in.next_key_type];
        use_cl_dscp = lookup_in.first_lookup ? use_cl_dscp_cfg_q[0]
                                             : use_cl_dscp_cfg_q[1];
    end

    always_comb begin
        key_d = '0;
        key_d.dst_entry              = dst_sel;
        key_d.ethertype_encoded_flag = type_overload_field_enc;
        key_d.ip_or_llc_subnet_flag  = ip_any || snap;
        key_d.ipv4_flag              = ip4;
        // destination MAC swapped in when destination select is on
        key_d.mac_key_field = dst_sel ? parse_in.dest_mac_field
                                      : parse_in.src_mac;
        key_d.ip_multicast_flag =
            (ip4 && parse_in.dst_ip[31:28] == `FCK_V4_MC_NIBBLE) ||
            (ip6 && parse_in.dst_ip6_top == `FCK_V6_MC_BYTE);
        // fragment and option flags are IPv4 only; options are not walked
        key_d.fragmented_flag =
            ip4 && (parse_in.more_frags || parse_in.frag_offset != 13'h0000);
        key_d.nonfirst_fragment_flag =
            ip4 && (parse_in.frag_offset != 13'h0000);
        key_d.header_options_flag = ip4 && (parse_in.ihl > `FCK_IHL_PLAIN);
        if (use_cl_dscp) begin
            key_d.dscp_key_field = lookup_in.classified_dscp;
        end else if (ip_any) begin
            key_d.dscp_key_field = parse_in.dscp;
        end
        if (ip_any) begin
            key_d.protocol_key_field = parse_in.protocol;
            key_d.dest_ip_field      = parse_in.dst_ip;
            key_d.stream_protocol_flag =
                parse_in.protocol == `FCK_PROTO_TCP;
        end
        // OAM Y.1731 overloads the transport flag regardless of frame type
        key_d.transport_flag =
            (ip_any && is_transport(parse_in.protocol)) ||
            parse_in.oam_y1731;
        // type overload field
        if (!type_overload_field_enc && !snap) begin
            key_d.type_overload_field = {parse_in.dsap, parse_in.ssap};
        end else if (!type_overload_field_enc) begin
            key_d.type_overload_field = {parse_in.snap_pid[4],
                                         parse_in.snap_pid[3]};
        end else if (ip_any && key_d.transport_flag) begin
            key_d.type_overload_field = parse_in.l4_dport;
        end else if (ip_any) begin
            key_d.type_overload_field = {8'h00, parse_in.protocol};
        end else begin
            key_d.type_overload_field = parse_in.type_len;
        end
        // source IP overload field
        if (!type_overload_field_enc && !snap) begin
            key_d.src_ip_overload_field = {parse_in.llc_ctrl, parse_in.payload[0],
                                           parse_in.payload[1],
                                           parse_in.payload[2]};
        end else if (!type_overload_field_enc) begin
            key_d.src_ip_overload_field = {parse_in.snap_pid[2], parse_in.snap_pid[1],
                                           parse_in.snap_pid[0],
                                           parse_in.payload[0]};
        end else if (ip_any) begin
            key_d.src_ip_overload_field = dst_sel ? parse_in.dst_ip
                                                  : parse_in.src_ip;
        end else begin
            key_d.src_ip_overload_field = parse_in.payload;
        end
    end

    // key pipeline stage; key holds its last value between frames
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            key_q <= '0;
        end else if (parse_valid_in) begin
            key_q <= key_d;
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            key_valid_q <= 1'b0;
        end else begin
            key_valid_q <= parse_valid_in;
        end
    end

    // frames keyed since reset, wraps; lets software see traffic
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            frame_cnt_q <= `FCK_CNT_RESET;
        end else if (parse_valid_in) begin
            frame_cnt_q <= frame_cnt_q + 16'h0001;
        end
    end

    // config writes; other offsets ignore writes
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            {use_cl_dscp_cfg_q, dst_sel_cfg_q} <= `FCK_CFG_RESET;
        end else if (reg_wr_in && reg_addr_in == `FCK_OFS_ADV_CFG) begin
            dst_sel_cfg_q     <= reg_wdata_in[`FCK_CFG_DST_LSB +: `FCK_CFG_DST_W];
            use_cl_dscp_cfg_q <= reg_wdata_in[`FCK_CFG_DSCP_LSB +: `FCK_CFG_DSCP_W];
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rdata_q <= 32'h0000_0000;
        end else if (reg_rd_in) begin
            unique case (reg_addr_in)
                `FCK_OFS_ADV_CFG:    rdata_q <= {26'h0000000, use_cl_dscp_cfg_q,
                                                 dst_sel_cfg_q};
                `FCK_OFS_FRAME_CNT:  rdata_q <= {16'h0000, frame_cnt_q};
                `FCK_OFS_LAST_FLAGS: rdata_q <= {22'h000000,
                                                 key_q.dst_entry,
                                                 key_q.stream_protocol_flag,
                                                 key_q.transport_flag,
                                                 key_q.header_options_flag,
                                                 key_q.nonfirst_fragment_flag,
                                                 key_q.fragmented_flag,
                                                 key_q.ipv4_flag,
                                                 key_q.ip_or_llc_subnet_flag,
                                                 key_q.ethertype_encoded_flag,
                                                 key_q.ip_multicast_flag};
                default:             rdata_q <= 32'h0000_0000;
            endcase
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    assign key_valid_out = key_valid_q;
    assign key_out       = key_q;
    assign reg_rdata_out = rdata_q;

    // checks
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);

    sequence s_frame;
        parse_valid_in;
    endsequence

    sequence s_dst_frame;
        parse_valid_in && dst_sel_cfg_q[lookup_in.next_key_type];
    endsequence

    a_dst_mac_swap: assert property (
        s_dst_frame |=> key_out.mac_key_field == $past(parse_in.dest_mac_field)
                        && key_out.dst_entry)
        else $error("destination select did not swap the MAC field");

    a_mc_flag: assert property (
        s_frame ##1 (key_out.ip_multicast_flag && !key_out.ipv4_flag) |->
            $past(parse_in.dst_ip6_top) == `FCK_V6_MC_BYTE)
        else $error("IPv6 multicast flag without top byte 0xFF");

    a_type_overload_field_flag: assert property (
        s_frame |=> key_out.ethertype_encoded_flag ==
                    ($past(parse_in.type_len) >= `FCK_TYPE_OVERLOAD_FIELD_MIN))
        else $error("ethertype flag wrong against the 0x600 threshold");

    a_llc_type_field: assert property (
        s_frame ##1 (!key_out.ethertype_encoded_flag && !key_out.ip_or_llc_subnet_flag)
            |-> key_out.type_overload_field == {$past(parse_in.dsap), $past(parse_in.ssap)})
        else $error("LLC type field is not DSAP and SSAP");

    a_transport_port: assert property (
        s_frame ##1 (key_out.ethertype_encoded_flag && key_out.ip_or_llc_subnet_flag
                     && key_out.transport_flag)
            |-> key_out.type_overload_field == $past(parse_in.l4_dport))
        else $error("TRANSPORT_FLAG type field is not the destination port");

    a_ipv4_flag: assert property (
        s_frame |=> key_out.ipv4_flag ==
            ($past(parse_in.type_len) == `FCK_TYPE_OVERLOAD_FIELD_IPV4 &&
             $past(parse_in.ip_version) == `FCK_IP_VER4))
        else $error("IPv4 flag does not follow type and version");

    a_frag_order: assert property (
        key_valid_out && key_out.nonfirst_fragment_flag |->
            key_out.fragmented_flag && key_out.ipv4_flag)
        else $error("non-first fragment without fragmented IPv4");

    a_options_flag: assert property (
        s_frame |=> key_out.header_options_flag ==
            (key_out.ipv4_flag && $past(parse_in.ihl) > `FCK_IHL_PLAIN))
        else $error("options flag disagrees with header length");

    a_dscp_select: assert property (
        (s_frame and use_cl_dscp) |=>
            key_out.dscp_key_field == $past(lookup_in.classified_dscp))
        else $error("classified DSCP not used when enabled");

    a_oam_transport: assert property (
        (s_frame and parse_in.oam_y1731) |=> key_out.transport_flag)
        else $error("OAM frame without transport flag");

    a_tcp_flag: assert property (
        key_valid_out && key_out.stream_protocol_flag |->
            key_out.protocol_key_field == `FCK_PROTO_TCP && key_out.transport_flag)
        else $error("stream flag without protocol 6");

    a_nonip_zero: assert property (
        key_valid_out && !(key_out.ethertype_encoded_flag && key_out.ip_or_llc_subnet_flag)
            |-> key_out.dest_ip_field == 32'h0000_0000 &&
                key_out.protocol_key_field == 8'h00)
        else $error("IP fields not zero for a non-IP frame");

    a_read_one_cycle: assert property (
        !reg_rd_in |=> reg_rdata_out == 32'h0000_0000)
        else $error("read data stands outside its cycle");

    a_key_pulse: assert property (
        key_valid_out == $past(parse_valid_in))
        else $error("key valid is not one cycle after the frame");

    a_key_hold: assert property (
        !parse_valid_in |=> $stable(key_out))
        else $error("key changed without a frame");

    a_frag_flag: assert property (
        s_frame |=> key_out.fragmented_flag == (key_out.ipv4_flag &&
            ($past(parse_in.more_frags) || $past(parse_in.frag_offset) != 13'h0000)))
        else $error("fragmented flag disagrees with the fragment fields");

    a_v4_mc_flag: assert property (
        s_frame ##1 key_out.ipv4_flag |->
            key_out.ip_multicast_flag == ($past(parse_in.dst_ip[31:28]) == `FCK_V4_MC_NIBBLE))
        else $error("IPv4 multicast flag disagrees with the top nibble");

    a_ip_fields: assert property (
        s_frame ##1 (key_out.ethertype_encoded_flag && key_out.ip_or_llc_subnet_flag) |->
            key_out.protocol_key_field == $past(parse_in.protocol) &&
            key_out.dest_ip_field == $past(parse_in.dst_ip))
        else $error("IP protocol or destination field not taken from the frame");

    a_snap_fields: assert property (
        s_frame ##1 (!key_out.ethertype_encoded_flag && key_out.ip_or_llc_subnet_flag) |->
            key_out.type_overload_field == $past(parse_in.snap_pid[4:3]) &&
            key_out.src_ip_overload_field == {$past(parse_in.snap_pid[2:0]),
                                              $past(parse_in.payload[0])})
        else $error("SNAP type or source field not taken from the PID");

    a_cfg_write: assert property (
        reg_wr_in && reg_addr_in == `FCK_OFS_ADV_CFG |=>
            {use_cl_dscp_cfg_q, dst_sel_cfg_q} == $past(reg_wdata_in[5:0]))
        else $error("config write did not land");

endmodule

`default_nettype wire

// >>> fck_lookup_sink.sv
// lookup engine model: counts keys it is handed and keeps the last one
// assumes keys arrive as one-cycle pulses on the shared core clock
`timescale 1ns/1ps
`default_nettype none

module fck_lookup_sink
    import fck_pkg::*;
(
    // clock and reset
    input  wire logic     sys_clk_in,
    input  wire logic     resetn_in,
    // key from the builder
    input  wire logic     key_valid_in,
    input  wire fck_key_t key_in,
    // observation
    output logic [15:0]   keys_seen_out,
    output fck_key_t      last_key_out
);
    // the engine never stalls, so every pulse must be taken
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            keys_seen_out <= 16'h0000;
        end else if (key_valid_in) begin
            keys_seen_out <= keys_seen_out + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            last_key_out <= '0;
        end else if (key_valid_in) begin
            last_key_out <= key_in;
        end
    end
endmodule

`default_nettype wire

// >>> fck_key_builder_tb_top.sv
// testbench for the classification key builder with a lookup engine model
// assumes a single core clock and fixed one-cycle key latency
`timescale 1ns/1ps
`default_nettype none
`include "fck_params.svh"

module fck_key_builder_tb_top import fck_pkg::*;;
    typedef logic [$bits(fck_key_t)-1:0] fck_wide_t;
    logic        sys_clk_in = 1'h0;
    logic        resetn_in = 1'h0;
    logic        parse_valid_in = 1'h0;
    fck_parse_t  parse_in = '0;
    fck_lookup_t lookup_in = '0;
    logic [7:0]  reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0;
    logic        reg_wr_in = 1'h0;
    logic        reg_rd_in = 1'h0;
    logic        key_valid_out;
    fck_key_t    key_out;
    logic [31:0] reg_rdata_out;
    logic [15:0] keys_seen;
    fck_key_t    last_key;
    fck_key_t    exp_last = '0;
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          n_frames = 0;
    int          cyc = 0;

    always #2.5 sys_clk_in = ~sys_clk_in;

    fck_key_builder u_fck_key_builder (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
        .parse_valid_in(parse_valid_in), .parse_in(parse_in), .lookup_in(lookup_in),
        .key_valid_out(key_valid_out), .key_out(key_out), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out));

    fck_lookup_sink u_fck_lookup_sink (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
        .key_valid_in(key_valid_out), .key_in(key_out), .keys_seen_out(keys_seen),
        .last_key_out(last_key));

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // the whole run is well under a hundred cycles
    always @(posedge sys_clk_in) begin
        cyc++;
        if (cyc == 2000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    task automatic chk(input fck_wide_t seen, input fck_wide_t exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // key latency is fixed at one cycle, so no polling is needed
    task automatic send(input fck_parse_t p, input fck_lookup_t l, input fck_key_t e);
        @(posedge sys_clk_in);
        parse_valid_in <= 1'h1;
        parse_in <= p;
        lookup_in <= l;
        @(posedge sys_clk_in);
        parse_valid_in <= 1'h0;
        #1;
        n_frames++;
        exp_last = e;
        chk(fck_wide_t'(key_valid_out), fck_wide_t'(1'h1));
        chk(key_out, e);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        reg_wr_in <= 1'h1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge sys_clk_in);
        reg_wr_in <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk_in);
        reg_rd_in <= 1'h1;
        reg_addr_in <= a;
        @(posedge sys_clk_in);
        reg_rd_in <= 1'h0;
        #1;
        chk(fck_wide_t'(reg_rdata_out), fck_wide_t'(e));
    endtask

    // ipv4 tcp frame with options, second fragment and multicast target
    function automatic fck_parse_t base_frame();
        fck_parse_t p;
        p = '0;
        p.dest_mac_field = 48'hD1D2D3D4D5D6;
        p.src_mac = 48'h515253545556;
        p.type_len = 16'h0800;
        p.ip_version = 4'h4;
        p.dsap = 8'h42;
        p.ssap = 8'h43;
        p.llc_ctrl = 8'h13;
        p.snap_pid = 40'h0102030405;
        p.payload = 32'hC0C1C2C3;
        p.frag_offset = 13'h0001;
        p.ihl = 4'h6;
        p.dscp = 6'h2A;
        p.protocol = 8'h06;
        p.src_ip = 32'h0A000001;
        p.dst_ip = 32'hE0000005;
        p.dst_ip6_top = 8'h20;
        p.l4_dport = 16'h1F90;
        return p;
    endfunction

    function automatic fck_key_t v4_key();
        fck_key_t k;
        k = '0;
        k.mac_key_field = 48'h515253545556;
        {k.ip_multicast_flag, k.ethertype_encoded_flag, k.ip_or_llc_subnet_flag} = 3'h7;
        {k.ipv4_flag, k.fragmented_flag, k.nonfirst_fragment_flag} = 3'h7;
        {k.header_options_flag, k.transport_flag, k.stream_protocol_flag} = 3'h7;
        k.type_overload_field = 16'h1F90;
        k.dscp_key_field = 6'h2A;
        k.dest_ip_field = 32'hE0000005;
        k.src_ip_overload_field = 32'h0A000001;
        k.protocol_key_field = 8'h06;
        return k;
    endfunction

    task automatic t_llc();
        fck_parse_t p;
        fck_key_t   k;
        p = base_frame();
        p.type_len = 16'h05FF;
        k = '0;
        k.mac_key_field = p.src_mac;
        k.type_overload_field = 16'h4243;
        k.src_ip_overload_field = 32'h13C0C1C2;
        send(p, '0, k);
        p.dsap = 8'hAA;
        p.ssap = 8'hAA;
        p.llc_ctrl = 8'h03;
        k.ip_or_llc_subnet_flag = 1'h1;
        k.type_overload_field = 16'h0102;
        k.src_ip_overload_field = 32'h030405C0;
        send(p, '0, k);
        $display("test llc_snap done");
    endtask

    task automatic t_ipv4();
        fck_parse_t p;
        fck_key_t   k;
        p = base_frame();
        send(p, '0, v4_key());
        p = base_frame();
        {p.ihl, p.frag_offset, p.more_frags} = {4'h5, 13'h0000, 1'h1};
        {p.protocol, p.dst_ip} = {8'h11, 32'hDFFFFFFF};
        k = v4_key();
        {k.ip_multicast_flag, k.nonfirst_fragment_flag} = 2'h0;
        {k.header_options_flag, k.stream_protocol_flag} = 2'h0;
        {k.protocol_key_field, k.dest_ip_field} = {8'h11, 32'hDFFFFFFF};
        send(p, '0, k);
        $display("test ipv4 done");
    endtask

    task automatic t_ipv6();
        fck_parse_t p;
        fck_key_t   k;
        p = base_frame();
        {p.type_len, p.ip_version, p.protocol} = {16'h86DD, 4'h6, 8'h3A};
        {p.dst_ip6_top, p.more_frags, p.ihl} = {8'hFF, 1'h1, 4'hF};
        k = v4_key();
        {k.ipv4_flag, k.fragmented_flag, k.nonfirst_fragment_flag} = 3'h0;
        {k.header_options_flag, k.transport_flag, k.stream_protocol_flag} = 3'h0;
        {k.protocol_key_field, k.type_overload_field} = {8'h3A, 16'h003A};
        send(p, '0, k);
        p.protocol = 8'h06;
        {k.transport_flag, k.stream_protocol_flag} = 2'h3;
        {k.protocol_key_field, k.type_overload_field} = {8'h06, 16'h1F90};
        send(p, '0, k);
        $display("test ipv6 done");
    endtask

    task automatic t_other();
        fck_parse_t p;
        fck_key_t   k;
        p = base_frame();
        p.type_len = 16'h0600;
        k = '0;
        k.mac_key_field = p.src_mac;
        k.ethertype_encoded_flag = 1'h1;
        k.type_overload_field = 16'h0600;
        k.src_ip_overload_field = 32'hC0C1C2C3;
        send(p, '0, k);
        {p.type_len, p.ip_version, p.oam_y1731} = {16'h0800, 4'h6, 1'h1};
        {k.type_overload_field, k.transport_flag} = {16'h0800, 1'h1};
        send(p, '0, k);
        $display("test other done");
    endtask

    task automatic t_cfg();
        fck_parse_t p;
        fck_key_t   k;
        p = base_frame();
        rd(`FCK_OFS_ADV_CFG, 32'h0);
        wr(`FCK_OFS_ADV_CFG, 32'h00000024);
        rd(`FCK_OFS_ADV_CFG, 32'h00000024);
        rd(8'h0C, 32'h0);
        wr(`FCK_OFS_FRAME_CNT, 32'h0000FFFF);
        rd(`FCK_OFS_FRAME_CNT, {16'h0000, n_frames[15:0]});
        k = v4_key();
        {k.mac_key_field, k.src_ip_overload_field} = {48'hD1D2D3D4D5D6, 32'hE0000005};
        {k.dst_entry, k.dscp_key_field} = {1'h1, 6'h15};
        send(p, {1'h0, 2'h2, 6'h15}, k);
        rd(`FCK_OFS_LAST_FLAGS, 32'h000003FF);
        k.dscp_key_field = 6'h2A;
        send(p, {1'h1, 2'h2, 6'h15}, k);
        k = v4_key();
        k.dscp_key_field = 6'h15;
        send(p, {1'h0, 2'h1, 6'h15}, k);
        rd(`FCK_OFS_LAST_FLAGS, 32'h000001FF);
        wr(`FCK_OFS_ADV_CFG, 32'h00000019);
        {k.mac_key_field, k.src_ip_overload_field} = {48'hD1D2D3D4D5D6, 32'hE0000005};
        k.dst_entry = 1'h1;
        send(p, {1'h1, 2'h3, 6'h15}, k);
        $display("test config done");
    endtask

    initial begin
        repeat (20) @(posedge sys_clk_in);
        resetn_in <= 1'h1;
        t_llc();
        t_ipv4();
        t_ipv6();
        t_other();
        t_cfg();
        repeat (2) @(posedge sys_clk_in);
        chk(fck_wide_t'(keys_seen), fck_wide_t'(n_frames[15:0]));
        chk(last_key, exp_last);
        report_and_stop();
    end
endmodule

`default_nettype wire
